// ===== rtl/wdt_pkg.sv
// constants, register map and types of the watchdog control block
package wdt_pkg;
   // ************************************************************
   // bus and counter geometry
   // ************************************************************
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 8;
   localparam int IRQ_W  = 2;

   // ************************************************************
   // register indices; byte address is four times the index
   // ************************************************************
   localparam logic [15:0] CTL_IDX   = 16'hffb1;
   localparam logic [15:0] CNT_IDX   = 16'hffb2;
   localparam logic [15:0] ISTAT_IDX = 16'hffb3;
   localparam logic [15:0] IMASK_IDX = 16'hffb4;

   // ************************************************************
   // control register fields
   // ************************************************************
   localparam int CWE_GUARD  = 7;
   localparam int CWE_BIT    = 6;
   localparam int RWE_GUARD  = 5;
   localparam int RWE_BIT    = 4;
   localparam int RUN_GUARD  = 3;
   localparam int RUN_BIT    = 2;
   localparam int FLAG_GUARD = 1;
   localparam int FLAG_BIT   = 0;
   localparam logic [7:0] GUARD_MASK = 8'haa;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic             CWE_RST   = 1'b0;
   localparam logic             RWE_RST   = 1'b0;
   localparam logic             RUN_RST   = 1'b1;
   localparam logic             FLAG_RST  = 1'b0;
   localparam logic [CNT_W-1:0] CNT_RST   = 8'h00;
   localparam logic [CNT_W-1:0] CNT_MAX   = 8'hff;
   localparam logic [IRQ_W-1:0] IMASK_RST = 2'h0;

   // ************************************************************
   // interrupt status bits and bus answers
   // ************************************************************
   localparam int IRQ_OVF = 0;
   localparam int IRQ_BLK = 1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SEL_CTL,
      SEL_CNT,
      SEL_ISTAT,
      SEL_IMASK,
      SEL_NONE
   } reg_sel_t;
endpackage : wdt_pkg

// ===== rtl/watchdog_ctrl.sv
// watchdog counter with guarded control register behind axi4-lite
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
module watchdog_ctrl
   import wdt_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output      logic              awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output      logic              wready,
   output      logic [1:0]        bresp,
   output      logic              bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output      logic              arready,
   output      logic [DATA_W-1:0] rdata,
   output      logic [1:0]        rresp,
   output      logic              rvalid,
   input  wire logic              rready,
   output      logic              chip_reset_req,
   output      logic              irq
);

   // ************************************************************
   // address decode
   // ************************************************************
   function automatic reg_sel_t sel_of(input logic [ADDR_W-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a[ADDR_W-1:2] == CTL_IDX) s = SEL_CTL;
      if (a[ADDR_W-1:2] == CNT_IDX) s = SEL_CNT;
      if (a[ADDR_W-1:2] == ISTAT_IDX) s = SEL_ISTAT;
      if (a[ADDR_W-1:2] == IMASK_IDX) s = SEL_IMASK;
      return s;
   endfunction : sel_of

   // ************************************************************
   // state
   // ************************************************************
   logic              aw_full_reg,  aw_full_next;
   logic [ADDR_W-1:0] aw_addr_reg,  aw_addr_next;
   logic              w_full_reg,   w_full_next;
   logic [7:0]        w_data_reg,   w_data_next;
   logic [CNT_W-1:0]  w_cnt_reg,    w_cnt_next;
   logic              w_lane_reg,   w_lane_next;
   logic              bvalid_reg,   bvalid_next;
   logic [1:0]        bresp_reg,    bresp_next;
   logic              rvalid_reg,   rvalid_next;
   logic [DATA_W-1:0] rdata_reg,    rdata_next;
   logic [1:0]        rresp_reg,    rresp_next;
   logic              cwe_reg,      cwe_next;
   logic              rwe_reg,      rwe_next;
   logic              run_reg,      run_next;
   logic              flag_reg,     flag_next;
   logic [CNT_W-1:0]  cnt_reg,      cnt_next;
   logic              req_reg,      req_next;
   logic [IRQ_W-1:0]  istat_reg,    istat_next;
   logic [IRQ_W-1:0]  imask_reg,    imask_next;

   // ************************************************************
   // bus handshakes
   // ************************************************************
   wire logic     aw_fire = ce && awvalid && awready;
   wire logic     w_fire  = ce && wvalid && wready;
   wire logic     ar_fire = ce && arvalid && arready;
   wire logic     do_wr   = ce && aw_full_reg && w_full_reg
                            && !bvalid_reg;
   wire reg_sel_t wsel    = sel_of(aw_addr_reg);
   wire reg_sel_t rsel    = sel_of(araddr);

   // ready stays low while frozen so no beat is lost
   assign awready = ce && !aw_full_reg && !bvalid_reg;
   assign wready  = ce && !w_full_reg && !bvalid_reg;
   assign arready = ce && !rvalid_reg;

   // ************************************************************
   // register write decode
   // ************************************************************
   // only the low byte lane reaches the 8-bit registers
   wire logic       wr_ctl = do_wr && wsel == SEL_CTL && w_lane_reg;
   wire logic       wr_cnt = do_wr && wsel == SEL_CNT && w_lane_reg;
   wire logic       wr_msk = do_wr && wsel == SEL_IMASK && w_lane_reg;
   wire logic [7:0] wd     = w_data_reg;
   wire logic       cnt_wr_ok  = wr_cnt && cwe_reg;
   wire logic       cnt_wr_blk = wr_cnt && !cwe_reg;
   wire logic       ctl_wr_ok  = wr_ctl && rwe_reg;
   wire logic       ovf_hit = ce && run_reg && cnt_reg == CNT_MAX
                              && !cnt_wr_ok;
   wire logic       rd_istat = ar_fire && rsel == SEL_ISTAT;

   // ************************************************************
   // control bits and counter
   // ************************************************************
   always_comb begin
      cwe_next  = cwe_reg;
      rwe_next  = rwe_reg;
      run_next  = run_reg;
      flag_next = flag_reg;
      cnt_next  = cnt_reg;
      if (wr_ctl && !wd[CWE_GUARD]) begin
         cwe_next = wd[CWE_BIT];
      end
      if (wr_ctl && !wd[RWE_GUARD]) begin
         rwe_next = wd[RWE_BIT];
      end
      // guarded run bit, set or clear
      if (ctl_wr_ok && !wd[RUN_GUARD]) begin
         run_next = wd[RUN_BIT];
      end
      // guarded flag, write may only clear
      if (ctl_wr_ok && !wd[FLAG_GUARD] && !wd[FLAG_BIT]) begin
         flag_next = 1'b0;
      end
      if (cnt_wr_ok) begin
         cnt_next = w_cnt_reg;
      end else if (run_reg) begin
         cnt_next = cnt_reg + 1'b1;
      end
      // overflow sets flag and wins over a clear
      // internal reset restores cwe, rwe, run and the counter, but not the flag, the interrupt mask or the status
      if (ovf_hit) begin
         cwe_next  = CWE_RST;
         rwe_next  = RWE_RST;
         run_next  = RUN_RST;
         cnt_next  = CNT_RST;
         flag_next = 1'b1;
      end
   end

   assign req_next = ovf_hit;

   // ************************************************************
   // interrupt status and mask
   // ************************************************************
   logic [IRQ_W-1:0] ev;
   always_comb begin
      ev          = '0;
      ev[IRQ_OVF] = ovf_hit;
      ev[IRQ_BLK] = cnt_wr_blk;
   end
   // a read clears, but an event in the same cycle wins
   assign istat_next = (rd_istat ? '0 : istat_reg) | ev;
   assign imask_next = wr_msk ? wd[IRQ_W-1:0] : imask_reg;
   assign irq        = |(istat_reg & imask_reg);

   // ************************************************************
   // write channel
   // ************************************************************
   assign aw_full_next = aw_fire ? 1'b1 : (do_wr ? 1'b0 : aw_full_reg);
   assign aw_addr_next = aw_fire ? awaddr : aw_addr_reg;
   assign w_full_next  = w_fire ? 1'b1 : (do_wr ? 1'b0 : w_full_reg);
   assign w_data_next  = w_fire ? wdata[7:0] : w_data_reg;
   assign w_cnt_next   = w_fire ? wdata[CNT_W-1:0] : w_cnt_reg;
   assign w_lane_next  = w_fire ? wstrb[0] : w_lane_reg;
   assign bvalid_next  = do_wr ? 1'b1
                       : ((bvalid_reg && bready) ? 1'b0 : bvalid_reg);
   assign bresp_next   = do_wr ? ((wsel == SEL_NONE) ? RESP_SLVERR
                                                     : RESP_OKAY)
                               : bresp_reg;

   // ************************************************************
   // read channel
   // ************************************************************
   logic [7:0] ctl_view;
   always_comb begin
      ctl_view             = GUARD_MASK;
      ctl_view[CWE_BIT]    = cwe_reg;
      ctl_view[RWE_BIT]    = rwe_reg;
      ctl_view[RUN_BIT]    = run_reg;
      ctl_view[FLAG_BIT]   = flag_reg;
   end

   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      unique case (rsel)
         SEL_CTL:   rd_mux[7:0]       = ctl_view;
         SEL_CNT:   rd_mux[CNT_W-1:0] = cnt_reg;
         SEL_ISTAT: rd_mux[IRQ_W-1:0] = istat_reg;
         SEL_IMASK: rd_mux[IRQ_W-1:0] = imask_reg;
         SEL_NONE:  rd_mux            = '0;
      endcase
   end

   assign rvalid_next = ar_fire ? 1'b1
                      : ((rvalid_reg && rready) ? 1'b0 : rvalid_reg);
   assign rdata_next  = ar_fire ? rd_mux : rdata_reg;
   assign rresp_next  = ar_fire ? ((rsel == SEL_NONE) ? RESP_SLVERR
                                                      : RESP_OKAY)
                                : rresp_reg;

   // ************************************************************
   // registers
   // ************************************************************
   // run set at reset, watchdog live at once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cwe_reg   <= CWE_RST;
         rwe_reg   <= RWE_RST;
         run_reg   <= RUN_RST;
         flag_reg  <= FLAG_RST;
         cnt_reg   <= CNT_RST;
         req_reg   <= 1'b0;
         istat_reg <= '0;
         imask_reg <= IMASK_RST;
      end else if (ce) begin
         cwe_reg   <= cwe_next;
         rwe_reg   <= rwe_next;
         run_reg   <= run_next;
         flag_reg  <= flag_next;
         cnt_reg   <= cnt_next;
         req_reg   <= req_next;
         istat_reg <= istat_next;
         imask_reg <= imask_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_full_reg  <= 1'b0;
         w_data_reg  <= '0;
         w_cnt_reg   <= '0;
         w_lane_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end else if (ce) begin
         aw_full_reg <= aw_full_next;
         aw_addr_reg <= aw_addr_next;
         w_full_reg  <= w_full_next;
         w_data_reg  <= w_data_next;
         w_cnt_reg   <= w_cnt_next;
         w_lane_reg  <= w_lane_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   assign bvalid         = bvalid_reg;
   assign bresp          = bresp_reg;
   assign rvalid         = rvalid_reg;
   assign rdata          = rdata_reg;
   assign rresp          = rresp_reg;
   assign chip_reset_req = req_reg;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_cwe_guard;
      wr_ctl && wd[CWE_GUARD] && !ovf_hit |=> $stable(cwe_reg);
   endproperty
   a_cwe_guard: assert property (p_cwe_guard)
      else $error("counter enable changed under guard");

   property p_cnt_locked;
      wr_cnt && !cwe_reg && !run_reg |=> $stable(cnt_reg);
   endproperty
   a_cnt_locked: assert property (p_cnt_locked)
      else $error("locked counter was written");

   property p_rwe_guard;
      wr_ctl && wd[RWE_GUARD] && !ovf_hit |=> $stable(rwe_reg);
   endproperty
   a_rwe_guard: assert property (p_rwe_guard)
      else $error("register enable changed under guard");

   property p_ctl_locked;
      wr_ctl && !rwe_reg && !ovf_hit
         |=> $stable(run_reg) && $stable(flag_reg);
   endproperty
   a_ctl_locked: assert property (p_ctl_locked)
      else $error("run or flag changed while locked");

   property p_run_write;
      wr_ctl && rwe_reg && !wd[RUN_GUARD] && !ovf_hit
         |=> run_reg == $past(wd[RUN_BIT]);
   endproperty
   a_run_write: assert property (p_run_write)
      else $error("run bit did not follow write");

   // sampled reset keeps the release edge, which does not count, out
   property p_count;
      !rst && ce && run_reg && !cnt_wr_ok && !ovf_hit
         |=> cnt_reg == $past(cnt_reg) + 1'b1;
   endproperty
   a_count: assert property (p_count)
      else $error("counter did not advance");

   property p_overflow;
      ovf_hit |=> flag_reg && run_reg && chip_reset_req
                  ##1 !chip_reset_req;
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow effects wrong");

   property p_flag_clear;
      wr_ctl && rwe_reg && !wd[FLAG_GUARD] && !wd[FLAG_BIT]
         && !ovf_hit |=> !flag_reg;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by write");

   property p_guard_read;
      ar_fire && rsel == SEL_CTL
         |=> rvalid && (rdata[7:0] & GUARD_MASK) == GUARD_MASK;
   endproperty
   a_guard_read: assert property (p_guard_read)
      else $error("guard bits did not read as one");

   property p_req_cause;
      chip_reset_req |-> $past(ovf_hit);
   endproperty
   a_req_cause: assert property (p_req_cause)
      else $error("reset request without overflow");

endmodule : watchdog_ctrl

// ===== tb/test_watchdog_ctrl_write_protect.sv
// self-checking testbench of the guarded watchdog control block
`timescale 1ns/10ps
module test_watchdog_ctrl_write_protect
   import wdt_pkg::*;
;
   logic              clk, rst, ce;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, resp;
   logic              arvalid, arready, rvalid, rready;
   logic              chip_reset_req, irq;
   logic [DATA_W-1:0] rv, c1;
   int                n_errors, checked;

   watchdog_ctrl u_watchdog_ctrl (
      .clk(clk), .rst(rst), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .chip_reset_req(chip_reset_req), .irq(irq)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [17:0] ba(input logic [15:0] idx);
      return {idx, 2'b00};
   endfunction : ba

   // expected control byte: guards always read back as one
   function automatic logic [31:0] ctl(input logic cwe, rwe, run, flg);
      return {24'h0, GUARD_MASK | {1'b0, cwe, 1'b0, rwe, 1'b0, run,
                                   1'b0, flg}};
   endfunction : ctl

   task automatic do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      int i;
      @(posedge clk);
      awaddr  <= ba(idx);
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      resp = bresp;
      bready <= 1'b0;
      if (i == 50) begin
         chk(1, 0);
         test_done;
      end
   endtask : wr

   task automatic rd(input logic [15:0] idx);
      int i;
      @(posedge clk);
      araddr  <= ba(idx);
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rv   = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (i == 50) begin
         chk(1, 0);
         test_done;
      end
   endtask : rd

   // bounded wait for the one-cycle overflow pulse
   task automatic wait_ovf;
      int i;
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         if (chip_reset_req === 1'b1) break;
      end
      chk(i < 300, 1);
      if (i == 300) begin
         test_done;
      end
      @(posedge clk);
      chk(chip_reset_req, 0);
   endtask : wait_ovf

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_guards;
      rd(CTL_IDX);
      chk(rv, ctl(0, 0, RUN_RST, 0));
      chk(irq, 0);
      wr(CTL_IDX, 32'h0000_00ff);
      rd(CTL_IDX);
      chk(rv, ctl(0, 0, 1, 0));
      wr(CTL_IDX, 32'h0000_00f3);
      rd(CTL_IDX);
      chk(rv, ctl(0, 0, 1, 0));
      $display("guard bits done");
   endtask : t_guards

   task automatic t_stop_counter;
      wr(CTL_IDX, 32'h0000_00df);
      rd(CTL_IDX);
      chk(rv, ctl(0, 1, 1, 0));
      wr(CTL_IDX, 32'h0000_00f3);
      rd(CTL_IDX);
      chk(rv, ctl(0, 1, 0, 0));
      rd(CNT_IDX);
      c1 = rv;
      repeat (5) @(posedge clk);
      rd(CNT_IDX);
      chk(rv, c1);
      wr(IMASK_IDX, 32'h0000_0002);
      wr(CNT_IDX, 32'h0000_0055);
      rd(CNT_IDX);
      chk(rv, c1);
      chk(irq, 1);
      rd(ISTAT_IDX);
      chk(rv, 32'h0000_0002);
      @(posedge clk);
      chk(irq, 0);
      wr(CTL_IDX, 32'h0000_007f);
      rd(CTL_IDX);
      chk(rv, ctl(1, 1, 0, 0));
      wr(CNT_IDX, 32'h0000_0055);
      rd(CNT_IDX);
      chk(rv, 32'h0000_0055);
      $display("stop and counter write done");
   endtask : t_stop_counter

   task automatic t_overflow;
      wr(IMASK_IDX, 32'h0000_0001);
      wr(CNT_IDX, 32'h0000_00f0);
      wr(CTL_IDX, 32'h0000_00f7);
      rd(CTL_IDX);
      chk(rv, ctl(1, 1, 1, 0));
      wait_ovf;
      rd(CTL_IDX);
      chk(rv, ctl(0, 0, 1, 1));
      chk(irq, 1);
      rd(ISTAT_IDX);
      chk(rv, 32'h0000_0001);
      wr(CTL_IDX, 32'h0000_00df);
      wr(CTL_IDX, 32'h0000_00fe);
      rd(CTL_IDX);
      chk(rv, ctl(0, 1, 1, 1));
      wr(CTL_IDX, 32'h0000_00fc);
      rd(CTL_IDX);
      chk(rv, ctl(0, 1, 1, 0));
      wait_ovf;
      do_reset;
      rd(CTL_IDX);
      chk(rv, ctl(0, 0, 1, 0));
      $display("overflow done");
   endtask : t_overflow

   task automatic t_unmapped;
      // write without byte lane 0 must leave the control bits alone
      wstrb <= 4'h0;
      wr(CTL_IDX, 32'h0000_007f);
      wstrb <= 4'h1;
      rd(CTL_IDX);
      chk(rv, ctl(0, 0, 1, 0));
      wr(16'h0000, 32'h0000_00ff);
      chk(resp, RESP_SLVERR);
      rd(16'h0000);
      chk(resp, RESP_SLVERR);
      chk(rv, 0);
      $display("unmapped done");
   endtask : t_unmapped

   initial begin
      n_errors = 0;
      checked  = 0;
      rst      = 1'b1;
      ce       = 1'b1;
      awaddr   = '0;
      araddr   = '0;
      wdata    = '0;
      wstrb    = 4'h1;
      awvalid  = 1'b0;
      wvalid   = 1'b0;
      bready   = 1'b0;
      arvalid  = 1'b0;
      rready   = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_guards;
      t_stop_counter;
      t_overflow;
      t_unmapped;
      test_done;
   end
endmodule : test_watchdog_ctrl_write_protect
